// *** clock_generator_pkg.sv ***
// shared constants for the clock generator
package clock_generator_pkg;

   // ---------------------------------------------------------------
   // clock and timing
   // ---------------------------------------------------------------
   localparam int          CLK_PERIOD_NS  = 10;
   localparam int          LOCK_TIME_US   = 35;
   localparam int          LOCK_CYCLES    = (LOCK_TIME_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int          LOCK_CNT_W     = 12;

   // ---------------------------------------------------------------
   // register bus
   // ---------------------------------------------------------------
   localparam int          ADDR_W         = 4;
   localparam int          DATA_W         = 16;
   localparam logic [3:0]  CTRL_OFFSET    = 4'h0;
   localparam logic [3:0]  OUTDIV_OFFSET  = 4'h4;
   localparam logic [3:0]  STATUS_OFFSET  = 4'h8;

   // control register fields
   localparam int          CTRL_PLL_EN_BIT = 0;
   localparam int          CTRL_MULT_LSB   = 1;
   localparam int          MULT_W          = 6;
   localparam logic [5:0]  MULT_MIN_Q      = 6'h04;
   localparam logic [5:0]  MULT_RESET_Q    = 6'h04;

   // output divide field: 00 undivided, 01 by two, 10 by three, 11 by four
   localparam int          OUTDIV_W       = 2;
   localparam logic [1:0]  OUTDIV_NONE    = 2'h0;
   localparam logic [1:0]  OUTDIV_RESET   = 2'h3;

   // status register fields
   localparam int          STAT_LOCK_BIT  = 0;
   localparam int          STAT_MODE_LSB  = 1;
   localparam int          STAT_OSC_BIT   = 4;
   localparam int          STAT_PLL_BIT   = 5;

   // ---------------------------------------------------------------
   // mode strap codes
   // ---------------------------------------------------------------
   localparam logic [2:0]  MODE_OSC_DIV2  = 3'h4;
   localparam logic [2:0]  MODE_EXT_DIV2  = 3'h7;
   localparam logic [2:0]  MODE_RESET     = 3'h0;

   // ---------------------------------------------------------------
   // reference period measurement and synthesis
   // ---------------------------------------------------------------
   localparam int          PERIOD_W       = 16;
   localparam int          ACC_W          = 19;
   localparam logic [15:0] PERIOD_MAX     = 16'hFFFF;

   typedef enum logic [1:0] {
      PLL_BYPASS  = 2'b00,
      PLL_LOCKING = 2'b01,
      PLL_LOCKED  = 2'b11
   } pll_state_e;

endpackage

// *** ref_edge_sync.sv ***
// two-flop synchroniser with rising-edge detect for the reference pin
`timescale 1ns/1ps
module ref_edge_sync (
   input  wire logic clk_i,
   input  wire logic resetn_i,
   input  wire logic async_i,
   output logic      level_o,
   output logic      rise_o
);

   logic meta_r;
   logic sync_r;
   logic prev_r;

   always_ff @(posedge clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         meta_r <= 1'b0;
         sync_r <= 1'b0;
         prev_r <= 1'b0;
      end else begin
         meta_r <= async_i;
         sync_r <= meta_r;
         prev_r <= sync_r;
      end
   end

   assign level_o = sync_r;
   assign rise_o  = sync_r & ~prev_r;

endmodule

// *** clock_generator_pll.sv ***
// clock generator: divide-by-two and fractional multiply paths, clock output divider
//
// Operation
// - machine cycle derives from reference clock divided by two, or by four at output.
// - mode pins 1,0,0 at reset enable the internal crystal oscillator.
// - with oscillator selected, machine clock is half the crystal rate after reset.
// - oscillator output can also serve as the multiply path reference.
// - external divide-by-two mode halves the external input clock.
// - multiply mode makes machine cycle equal reference rate times factor N.
// - multipliers 1 to 15 plus fractions of one quarter, half, three quarters.
// - after a multiplier change, output is unlocked for 35 microseconds.
// - output divide field 00 drives clock output undivided.
// - reset sets output divide field to divide by four.
// - logic is static, holding state as reference frequency approaches zero.
`timescale 1ns/1ps
module clock_generator_pll
   import clock_generator_pkg::*;
(
   input  wire logic               clk_i,
   input  wire logic               resetn_i,
   input  wire logic               reference_clock_input_i,
   input  wire logic [2:0]         clock_mode_select_pins_i,
   input  wire logic [ADDR_W-1:0]  addr_i,
   input  wire logic [DATA_W-1:0]  wdata_i,
   input  wire logic               wr_i,
   input  wire logic               rd_i,
   output logic      [DATA_W-1:0]  rdata_o,
   output logic                    crystal_drive_pin_o,
   output logic                    osc_enable_o,
   output logic                    machine_tick_o,
   output logic                    machine_clock_output_o,
   output logic                    pll_locked_o
);

   // ---------------------------------------------------------------
   // input synchronisation
   // ---------------------------------------------------------------
   logic       ref_level;
   logic       ref_rise;
   logic [2:0] mode_meta_r;
   logic [2:0] mode_sync_r;

   ref_edge_sync u_ref_sync (
      .clk_i    (clk_i),
      .resetn_i (resetn_i),
      .async_i  (reference_clock_input_i),
      .level_o  (ref_level),
      .rise_o   (ref_rise)
   );

   always_ff @(posedge clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         mode_meta_r <= MODE_RESET;
         mode_sync_r <= MODE_RESET;
      end else begin
         mode_meta_r <= clock_mode_select_pins_i;
         mode_sync_r <= mode_meta_r;
      end
   end

   // ---------------------------------------------------------------
   // strap capture
   // ---------------------------------------------------------------
   logic [2:0] mode_r;
   logic [1:0] strap_cnt_r;
   logic       osc_en_r;

   // every strap code, the oscillator one included, starts on the halved reference
   // pins need two edges through the synchroniser before they are valid
   // capture on the third clock after release
   always_ff @(posedge clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         strap_cnt_r <= 2'h0;
         mode_r      <= MODE_RESET;
         osc_en_r    <= 1'b0;
      end else if (strap_cnt_r != 2'h3) begin
         strap_cnt_r <= strap_cnt_r + 2'h1;
         if (strap_cnt_r == 2'h2) begin
            mode_r   <= mode_sync_r;
            osc_en_r <= (mode_sync_r == MODE_OSC_DIV2);
         end
      end
   end

   // ---------------------------------------------------------------
   // crystal drive
   // ---------------------------------------------------------------
   // oscillator feeds the same reference path
   always_ff @(posedge clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         crystal_drive_pin_o <= 1'b0;
      end else begin
         crystal_drive_pin_o <= osc_en_r & ~ref_level;
      end
   end

   assign osc_enable_o = osc_en_r;

   // ---------------------------------------------------------------
   // registers
   // ---------------------------------------------------------------
   // one compare for every offset so reads and writes cannot disagree
   function automatic logic offset_hit(input logic [ADDR_W-1:0] addr, input logic [ADDR_W-1:0] offset);
      offset_hit = (addr == offset);
   endfunction

   logic                pll_en_r;
   logic [MULT_W-1:0]   mult_q_r;
   logic [OUTDIV_W-1:0] outdiv_r;
   logic                reprogram;
   logic [MULT_W-1:0]   wr_mult;
   logic                ctrl_wr;
   logic                outdiv_wr;
   logic [DATA_W-1:0]   ctrl_word;
   logic [DATA_W-1:0]   status_word;
   pll_state_e          state_r;

   assign ctrl_wr     = wr_i && offset_hit(addr_i, CTRL_OFFSET);
   assign outdiv_wr   = wr_i && offset_hit(addr_i, OUTDIV_OFFSET);
   assign wr_mult     = wdata_i[CTRL_MULT_LSB +: MULT_W];
   assign reprogram   = ctrl_wr && (wr_mult >= MULT_MIN_Q);
   assign ctrl_word   = DATA_W'({mult_q_r, pll_en_r});
   assign status_word = DATA_W'({(state_r != PLL_BYPASS), osc_en_r, mode_r, pll_locked_o});

   // software sets factor; quarters of 1.00 up to 15.75
   always_ff @(posedge clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         pll_en_r <= 1'b0;
         mult_q_r <= MULT_RESET_Q;
      end else if (reprogram) begin
         pll_en_r <= wdata_i[CTRL_PLL_EN_BIT];
         mult_q_r <= wr_mult;
      end
   end

   always_ff @(posedge clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         outdiv_r <= OUTDIV_RESET;
      end else if (outdiv_wr) begin
         outdiv_r <= wdata_i[OUTDIV_W-1:0];
      end
   end

   always_ff @(posedge clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         rdata_o <= '0;
      end else if (rd_i) begin
         if (offset_hit(addr_i, CTRL_OFFSET)) begin
            rdata_o <= ctrl_word;
         end else if (offset_hit(addr_i, OUTDIV_OFFSET)) begin
            rdata_o <= DATA_W'(outdiv_r);
         end else if (offset_hit(addr_i, STATUS_OFFSET)) begin
            rdata_o <= status_word;
         end else begin
            rdata_o <= '0;
         end
      end else begin
         rdata_o <= '0;
      end
   end

   // ---------------------------------------------------------------
   // lock sequencing
   // ---------------------------------------------------------------
   logic [LOCK_CNT_W-1:0] lock_cnt_r;

   // rewriting the same value still restarts the wait
   // 35 us unlocked after each reprogram that sets the enable bit; with it clear the state stays in bypass
   always_ff @(posedge clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         state_r    <= PLL_BYPASS;
         lock_cnt_r <= '0;
      end else if (reprogram) begin
         state_r    <= wdata_i[CTRL_PLL_EN_BIT] ? PLL_LOCKING : PLL_BYPASS;
         lock_cnt_r <= '0;
      end else begin
         case (state_r)
            PLL_LOCKING: begin
               if (lock_cnt_r == LOCK_CNT_W'(LOCK_CYCLES - 1)) begin
                  state_r <= PLL_LOCKED;
               end else begin
                  lock_cnt_r <= lock_cnt_r + 1'b1;
               end
            end
            PLL_LOCKED: begin
               state_r <= PLL_LOCKED;
            end
            default: begin
               state_r <= PLL_BYPASS;
            end
         endcase
      end
   end

   assign pll_locked_o = (state_r == PLL_LOCKED);

   // ---------------------------------------------------------------
   // reference period measurement
   // ---------------------------------------------------------------
   // saturates instead of wrapping so an edge after a long stop captures PERIOD_MAX, not a short period
   logic [PERIOD_W-1:0] period_cnt_r;
   logic [PERIOD_W-1:0] period_r;

   // the first period after reset is partial; the lock wait outlasts it
   // static, nothing times out
   always_ff @(posedge clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         period_cnt_r <= '0;
         period_r     <= PERIOD_MAX;
      end else if (ref_rise) begin
         period_cnt_r <= PERIOD_W'(1);
         period_r     <= period_cnt_r;
      end else if (period_cnt_r != PERIOD_MAX) begin
         period_cnt_r <= period_cnt_r + 1'b1;
      end
   end

   // ---------------------------------------------------------------
   // machine cycle generation
   // ---------------------------------------------------------------
   logic             half_r;
   logic [ACC_W-1:0] acc_r;
   logic [ACC_W-1:0] acc_sum;
   logic [ACC_W-1:0] acc_limit;
   logic             nco_tick;
   logic             div2_tick;

   // halve the reference; use this path
   always_ff @(posedge clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         half_r <= 1'b0;
      end else if (ref_rise) begin
         half_r <= ~half_r;
      end
   end

   assign div2_tick = ref_rise & half_r;

   // one tick per 4*period/mult_q clocks, so N times the reference rate
   assign acc_sum   = acc_r + ACC_W'(mult_q_r);
   assign acc_limit = ACC_W'({period_r, 2'b00});
   assign nco_tick  = (acc_sum >= acc_limit);

   // multiply path, cleared while unlocked or while period_r is saturated
   always_ff @(posedge clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         acc_r <= '0;
      end else if (state_r != PLL_LOCKED || period_r == PERIOD_MAX) begin
         acc_r <= '0;
      end else if (nco_tick) begin
         acc_r <= acc_sum - acc_limit;
      end else begin
         acc_r <= acc_sum;
      end
   end

   // ---------------------------------------------------------------
   // machine tick output
   // ---------------------------------------------------------------
   // during the lock wait the halved reference keeps the core running
   always_ff @(posedge clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         machine_tick_o <= 1'b0;
      end else if (state_r == PLL_LOCKED) begin
         machine_tick_o <= nco_tick && (period_r != PERIOD_MAX);
      end else begin
         machine_tick_o <= div2_tick;
      end
   end

   // ---------------------------------------------------------------
   // clock output divider
   // ---------------------------------------------------------------
   logic [OUTDIV_W-1:0] out_cnt_r;

   // one pulse per divided cycle, not a square wave
   // >= lets a field shrunk mid-count restart at once instead of wrapping
   // field 00 passes every machine cycle
   always_ff @(posedge clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         out_cnt_r              <= '0;
         machine_clock_output_o <= 1'b0;
      end else if (machine_tick_o) begin
         if (outdiv_r == OUTDIV_NONE || out_cnt_r >= outdiv_r) begin
            out_cnt_r              <= '0;
            machine_clock_output_o <= 1'b1;
         end else begin
            out_cnt_r              <= out_cnt_r + 1'b1;
            machine_clock_output_o <= 1'b0;
         end
      end else begin
         machine_clock_output_o <= 1'b0;
      end
   end

endmodule

// *** clock_generator_asserts.sv ***
// port-level assertion checker for the clock generator
`timescale 1ns/1ps
module clock_generator_asserts
   import clock_generator_pkg::*;
(
   input  wire logic              clk_i,
   input  wire logic              resetn_i,
   input  wire logic              reference_clock_input_i,
   input  wire logic [2:0]        clock_mode_select_pins_i,
   input  wire logic [ADDR_W-1:0] addr_i,
   input  wire logic [DATA_W-1:0] wdata_i,
   input  wire logic              wr_i,
   input  wire logic              rd_i,
   input  wire logic [DATA_W-1:0] rdata_o,
   input  wire logic              crystal_drive_pin_o,
   input  wire logic              osc_enable_o,
   input  wire logic              machine_tick_o,
   input  wire logic              machine_clock_output_o,
   input  wire logic              pll_locked_o
);
   logic        ctrl_wr;
   logic [12:0] since_wr_r;
   assign ctrl_wr = wr_i && addr_i == CTRL_OFFSET && wdata_i[6:1] >= MULT_MIN_Q;
   // saturates so a long locked run never wraps
   always_ff @(posedge clk_i or negedge resetn_i) begin
      if (!resetn_i) since_wr_r <= 13'h0;
      else if (ctrl_wr) since_wr_r <= 13'h0;
      else if (since_wr_r != 13'h1FFF) since_wr_r <= since_wr_r + 13'h1;
   end
   // ---------------------------------------------------------------
   // assertions
   // ---------------------------------------------------------------
   default clocking @(posedge clk_i); endclocking
   default disable iff (!resetn_i);
   chk_machine_clock_output_on_tick: assert property (machine_clock_output_o |-> $past(machine_tick_o))
      else $error("divided output without machine tick");
   chk_xtal_idle: assert property (!osc_enable_o && !$past(osc_enable_o) |-> !crystal_drive_pin_o)
      else $error("crystal drive active with oscillator off");
   chk_lock_restart: assert property (ctrl_wr |=> !pll_locked_o)
      else $error("lock held across multiplier change");
   chk_lock_time: assert property ($rose(pll_locked_o) |-> since_wr_r >= 13'd3498 && since_wr_r <= 13'd3503)
      else $error("lock wait length wrong");
   chk_lock_hold: assert property (pll_locked_o && !ctrl_wr |=> pll_locked_o)
      else $error("lock dropped without a write");
   chk_bypass_gap: assert property (machine_tick_o && !pll_locked_o && !$past(pll_locked_o)
      |=> (!machine_tick_o || pll_locked_o)[*8])
      else $error("bypass ticks too close");
   chk_osc_kept: assert property (!$fell(osc_enable_o))
      else $error("oscillator enable lost outside reset");
   chk_status_mirror: assert property (rd_i && addr_i == STATUS_OFFSET |=> rdata_o[STAT_LOCK_BIT] ==
      $past(pll_locked_o) && rdata_o[STAT_OSC_BIT] == $past(osc_enable_o))
      else $error("status read disagrees with outputs");
   cover property ($rose(pll_locked_o));
   cover property (machine_clock_output_o && osc_enable_o);
   cover property (rd_i && addr_i == STATUS_OFFSET);
endmodule

// *** ref_clock_source.sv ***
// reference clock source standing in for the crystal or external oscillator
`timescale 1ns/1ps
module ref_clock_source (
   input  wire logic       run_i,
   input  wire logic [7:0] half_i,
   output logic            ref_o
);
   int steps;
   initial begin
      ref_o = 1'b0;
      steps = 0;
      #3;
      forever begin
         #10;
         // free-running source, half period counted in 10 ns steps
         if (run_i) begin
            steps++;
            if (steps >= int'(half_i)) begin
               ref_o = ~ref_o;
               steps = 0;
            end
         end
         // a stopped source holds its level at once, no late toggle
      end
   end
endmodule

// *** testbench.sv ***
// self-checking bench for the clock generator
`timescale 1ns/1ps
module testbench
   import clock_generator_pkg::*;
;
   logic        clk, resetn, wr, rd, run, refc, xtal, osc_en, tick, machine_clock_output, locked;
   logic [2:0]  pins;
   logic [3:0]  addr;
   logic [15:0] wdata, rdata;
   logic [7:0]  half;
   int          mismatches, total_checks, n;
   clock_generator_pll dut (.clk_i(clk), .resetn_i(resetn), .reference_clock_input_i(refc),
      .clock_mode_select_pins_i(pins), .addr_i(addr), .wdata_i(wdata), .wr_i(wr), .rd_i(rd),
      .rdata_o(rdata), .crystal_drive_pin_o(xtal), .osc_enable_o(osc_en), .machine_tick_o(tick),
      .machine_clock_output_o(machine_clock_output), .pll_locked_o(locked));
   ref_clock_source src (.run_i(run), .half_i(half), .ref_o(refc));
   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end
   // ---------------------------------------------------------------
   // tasks
   // ---------------------------------------------------------------
   task automatic check(input logic [15:0] seen, input logic [15:0] exp);
      total_checks++;
      if (seen !== exp) begin
         mismatches++;
         $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   // counts may straddle a window edge by one
   task automatic near(input int got, input int exp);
      if (got >= exp - 1 && got <= exp + 1) check(16'(exp), 16'(exp));
      else check(16'(got), 16'(exp));
   endtask
   task automatic wr_reg(input logic [3:0] a, input logic [15:0] d);
      @(posedge clk);
      addr <= a;
      wdata <= d;
      wr <= 1'b1;
      @(posedge clk);
      wr <= 1'b0;
   endtask
   task automatic rd_reg(input logic [3:0] a, input logic [15:0] exp);
      @(posedge clk);
      addr <= a;
      rd <= 1'b1;
      @(posedge clk);
      rd <= 1'b0;
      #1 check(rdata, exp);
   endtask
   task automatic count_ticks(input int cyc, output int cnt);
      cnt = 0;
      repeat (cyc) begin
         @(posedge clk);
         #1 cnt += int'(tick);
      end
   endtask
   // reference period is 80 clocks, so 160 clocks hold exactly two periods
   task automatic count_drive(output int cnt);
      cnt = 0;
      repeat (160) begin
         @(posedge clk);
         #1 cnt += int'(xtal);
      end
   endtask
   task automatic ticks_per_out(output int cnt);
      int k;
      k = 0;
      cnt = 0;
      while (machine_clock_output !== 1'b1 && k < 4000) begin
         @(posedge clk);
         #1 k++;
      end
      do begin
         @(posedge clk);
         #1 k++;
         cnt += int'(tick);
      end while (machine_clock_output !== 1'b1 && k < 8000);
   endtask
   task automatic do_reset(input logic [2:0] strap);
      @(posedge clk);
      resetn <= 1'b0;
      pins <= strap;
      repeat (4) @(posedge clk);
      resetn <= 1'b1;
      repeat (6) @(posedge clk);
   endtask
   task automatic print_verdict;
      $display("checks=%0d mismatches=%0d", total_checks, mismatches);
      if (mismatches == 0 && total_checks > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask
   // ---------------------------------------------------------------
   // sequence
   // ---------------------------------------------------------------
   initial begin
      {wr, rd, addr, wdata, mismatches, total_checks} = '0;
      resetn = 1'b0;
      run = 1'b1;
      half = 8'h28;
      pins = MODE_OSC_DIV2;
      do_reset(MODE_OSC_DIV2);
      check({15'h0, osc_en}, 16'h0001);
      count_drive(n);
      check(16'(n), 16'h0050);
      rd_reg(STATUS_OFFSET, 16'h0018);
      rd_reg(OUTDIV_OFFSET, 16'h0003);
      rd_reg(4'hC, 16'h0000);
      count_ticks(1600, n);
      near(n, 10);
      ticks_per_out(n);
      check(16'(n), 16'h0004);
      for (int d = 0; d < 4; d++) begin
         wr_reg(OUTDIV_OFFSET, 16'(d));
         ticks_per_out(n);
         ticks_per_out(n);
         check(16'(n), 16'(d == 0 ? 1 : d + 1));
      end
      wr_reg(CTRL_OFFSET, 16'h0007);
      rd_reg(CTRL_OFFSET, 16'h0008);
      for (int i = 0; i < 4; i++) begin
         automatic logic [5:0] q = (i == 0) ? 6'h05 : (i == 1) ? 6'h06 : (i == 2) ? 6'h07 : 6'h3C;
         // software sets the factor before using the multiplied clock
         wr_reg(CTRL_OFFSET, {9'h0, q, 1'b1});
         @(posedge clk);
         #1 check({15'h0, locked}, 16'h0000);
         repeat (3400) @(posedge clk);
         #1 check({15'h0, locked}, 16'h0000);
         repeat (200) @(posedge clk);
         #1 check({15'h0, locked}, 16'h0001);
         // window spans sixteen reference periods, factor kept under one tick per clock
         count_ticks(1280, n);
         near(n, 4 * int'(q));
      end
      rd_reg(STATUS_OFFSET, 16'h0039);
      do_reset(MODE_EXT_DIV2);
      pins <= MODE_OSC_DIV2;
      check({15'h0, osc_en}, 16'h0000);
      count_drive(n);
      check(16'(n), 16'h0000);
      rd_reg(STATUS_OFFSET, 16'h000E);
      count_ticks(1600, n);
      near(n, 10);
      wr_reg(OUTDIV_OFFSET, 16'h0001);
      run <= 1'b0;
      // let an edge already in the synchroniser drain before counting
      repeat (8) @(posedge clk);
      count_ticks(1000, n);
      check(16'(n), 16'h0000);
      run <= 1'b1;
      ticks_per_out(n);
      ticks_per_out(n);
      check(16'(n), 16'h0002);
      print_verdict;
   end
   initial begin
      #1_000_000;
      mismatches++;
      print_verdict;
   end
endmodule
bind clock_generator_pll clock_generator_asserts u_chk (.clk_i(clk_i), .resetn_i(resetn_i),
   .reference_clock_input_i(reference_clock_input_i), .clock_mode_select_pins_i(clock_mode_select_pins_i),
   .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
   .crystal_drive_pin_o(crystal_drive_pin_o), .osc_enable_o(osc_enable_o), .machine_tick_o(machine_tick_o),
   .machine_clock_output_o(machine_clock_output_o), .pll_locked_o(pll_locked_o));
